// File: src/tsfs_pkg.sv
// Package with register map, field layout, reset values and states of the frame synchroniser.
package tsfs_pkg;
    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ACQ_THRESH_ADDR = 8'h00;
    localparam logic [7:0] TRK_THRESH_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam logic [7:0] VIT_CONFIG_ADDR = 8'h0C;
    localparam logic [7:0] TPS_STATUS_ADDR = 8'h10;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h14;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h18;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_UNCORR_BIT = 1;
    localparam int STAT_TPS_LOCK_BIT = 2;
    localparam int VIT_FIX_BIT = 3;
    localparam int TPS_VALID_BIT = 7;
    localparam int IRQ_LOCK_GAIN_BIT = 0;
    localparam int IRQ_LOCK_LOSS_BIT = 1;
    localparam int IRQ_UNCORR_BIT = 2;
    localparam int IRQ_WIDTH = 3;
    localparam int RATE_WIDTH = 3;
    localparam logic [7:0] ACQ_THRESH_RESET = 8'h03;
    localparam logic [7:0] TRK_THRESH_RESET = 8'h03;
    localparam logic [3:0] VIT_CONFIG_RESET = 4'h0;

    // ----------------------------------------------------------------
    // Stream constants
    // ----------------------------------------------------------------
    localparam logic [7:0] SYNC_NORMAL = 8'h47;
    localparam logic [7:0] SYNC_INVERTED = 8'hB8;
    localparam logic [7:0] PACKET_LENGTH = 8'hBC;

    typedef enum logic [1:0] {
        HUNT = 2'b00,
        VERIFY = 2'b01,
        TRACK = 2'b10
    } tsfs_state_type;
endpackage

// File: src/tsfs_sync_detect.sv
// Sync byte matcher for normal and inverted transport sync values.
module tsfs_sync_detect
(
    input wire logic [7:0] byteIn, // Decoded stream byte.
    output logic isSync // High when the byte is a sync value.
);
    assign isSync = (byteIn == tsfs_pkg::SYNC_NORMAL) || // RULE1
                    (byteIn == tsfs_pkg::SYNC_INVERTED); // RULE1
endmodule

// File: src/ts_frame_sync_control.sv
// Transport stream frame synchroniser with APB registers and interrupt.
// How it works
// RULE1: Packet boundaries are found by matching the bytes 47h and B8h in the decoded stream.
// RULE2: Acquisition and tracking thresholds are separate writable registers steering lock.
// RULE3: Writing a larger acquisition threshold while locked sends the engine back to hunting.
// RULE4: Hardware reset restores both thresholds, and software must rewrite them afterwards.
// RULE5: Software may watch the uncorrectable flag during lock and raise the threshold if needed.
// RULE6: A code rate written to the Viterbi configuration register is applied instead of a search.
// RULE7: The transmission-parameter code rate reads as valid only once that signalling is locked.
// RULE8: The lock output is high exactly while the synchroniser is in tracking state.
// RULE9: The packet error output flags packets with uncorrectable errors from the RS decoder.
// RULE10: Lock comes after the acquire count of spaced syncs, and goes after the track count of misses.
module ts_frame_sync_control
(
    input wire logic sys_clk, // System clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB write direction.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error for unmapped address.
    input wire logic [7:0] byteIn, // Decoded stream byte.
    input wire logic byteValid, // Byte strobe.
    input wire logic rsUncorrectable, // RS error for the packet now in flight.
    input wire logic tpsLock, // Transmission-parameter signalling locked.
    input wire logic [2:0] tpsCodeRate, // Decoded code rate from signalling.
    output logic frameLockOut, // Frame synchroniser in lock.
    output logic packetErrorOut, // Current packet uncorrectable.
    output logic packetStartOut, // Pulse on an accepted sync byte while locked.
    output logic [2:0] viterbiCodeRate, // Code rate to the Viterbi decoder.
    output logic viterbiRateFixed, // Viterbi uses the written rate, no search.
    output logic irq // Level interrupt.
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam int IRQ_W = tsfs_pkg::IRQ_WIDTH;
    tsfs_pkg::tsfs_state_type state_q;
    logic [7:0] acqThresh_q;
    logic [7:0] trkThresh_q;
    logic [3:0] vitConfig_q;
    logic [IRQ_W-1:0] irqStatus_q;
    logic [IRQ_W-1:0] irqMask_q;
    logic [7:0] position_q;
    logic [7:0] hitCount_q;
    logic [7:0] missCount_q;
    logic packetError_q;
    logic packetStart_q;
    logic [31:0] prdata_q;
    logic isSync;
    logic atBoundary;
    logic wrEn;
    logic rdEn;
    logic mapped;
    logic acqRaised;
    logic lockGain;
    logic lockLoss;
    logic [IRQ_W-1:0] irqEvents;

    tsfs_sync_detect u_detect
    (
        .byteIn(byteIn),
        .isSync(isSync)
    );

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign mapped = (paddr == tsfs_pkg::ACQ_THRESH_ADDR) || (paddr == tsfs_pkg::TRK_THRESH_ADDR) ||
                    (paddr == tsfs_pkg::STATUS_ADDR) || (paddr == tsfs_pkg::VIT_CONFIG_ADDR) ||
                    (paddr == tsfs_pkg::TPS_STATUS_ADDR) || (paddr == tsfs_pkg::IRQ_STATUS_ADDR) ||
                    (paddr == tsfs_pkg::IRQ_MASK_ADDR);
    assign pslverr = psel && penable && !mapped;
    assign acqRaised = wrEn && (paddr == tsfs_pkg::ACQ_THRESH_ADDR) &&
                       (pwdata[7:0] > acqThresh_q);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acqThresh_q <= tsfs_pkg::ACQ_THRESH_RESET; // RULE4
            trkThresh_q <= tsfs_pkg::TRK_THRESH_RESET; // RULE4
        end
        else if (wrEn && paddr == tsfs_pkg::ACQ_THRESH_ADDR)
        begin
            acqThresh_q <= pwdata[7:0]; // RULE2
        end
        else if (wrEn && paddr == tsfs_pkg::TRK_THRESH_ADDR)
        begin
            trkThresh_q <= pwdata[7:0]; // RULE2
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            vitConfig_q <= tsfs_pkg::VIT_CONFIG_RESET;
        end
        else if (wrEn && paddr == tsfs_pkg::VIT_CONFIG_ADDR)
        begin
            vitConfig_q <= pwdata[3:0]; // RULE6
        end
    end

    assign viterbiCodeRate = vitConfig_q[2:0]; // RULE6
    assign viterbiRateFixed = vitConfig_q[tsfs_pkg::VIT_FIX_BIT]; // RULE6

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prdata_q <= 32'h0000_0000;
        end
        else if (psel && !penable && !pwrite)
        begin
            prdata_q <= 32'h0000_0000;
            case (paddr)
                tsfs_pkg::ACQ_THRESH_ADDR: prdata_q[7:0] <= acqThresh_q;
                tsfs_pkg::TRK_THRESH_ADDR: prdata_q[7:0] <= trkThresh_q;
                tsfs_pkg::STATUS_ADDR:
                begin
                    prdata_q[tsfs_pkg::STAT_LOCK_BIT] <= frameLockOut;
                    prdata_q[tsfs_pkg::STAT_UNCORR_BIT] <= packetError_q; // RULE5
                    prdata_q[tsfs_pkg::STAT_TPS_LOCK_BIT] <= tpsLock;
                end
                tsfs_pkg::VIT_CONFIG_ADDR: prdata_q[3:0] <= vitConfig_q;
                tsfs_pkg::TPS_STATUS_ADDR:
                begin
                    // Stale rates before signalling lock would mislead the copy into the decoder.
                    if (tpsLock)
                    begin
                        prdata_q[2:0] <= tpsCodeRate; // RULE7
                        prdata_q[tsfs_pkg::TPS_VALID_BIT] <= 1'b1; // RULE7
                    end
                end
                tsfs_pkg::IRQ_STATUS_ADDR: prdata_q[IRQ_W-1:0] <= irqStatus_q;
                tsfs_pkg::IRQ_MASK_ADDR: prdata_q[IRQ_W-1:0] <= irqMask_q;
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = rdEn ? prdata_q : 32'h0000_0000;

    // ----------------------------------------------------------------
    // Sync engine
    // ----------------------------------------------------------------
    assign atBoundary = (position_q == tsfs_pkg::PACKET_LENGTH - 8'h01);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= tsfs_pkg::HUNT;
            position_q <= 8'h00;
            hitCount_q <= 8'h00;
            missCount_q <= 8'h00;
        end
        else if (acqRaised)
        begin
            state_q <= tsfs_pkg::HUNT; // RULE3
            hitCount_q <= 8'h00; // RULE3
            missCount_q <= 8'h00;
            position_q <= 8'h00;
        end
        else if (byteValid)
        begin
            position_q <= atBoundary ? 8'h00 : position_q + 8'h01;
            case (state_q)
                tsfs_pkg::HUNT:
                begin
                    if (isSync) // RULE1
                    begin
                        position_q <= 8'h00;
                        hitCount_q <= 8'h01;
                        // A direct jump into tracking must not inherit misses from the last loss.
                        missCount_q <= 8'h00;
                        state_q <= (acqThresh_q <= 8'h01) ? tsfs_pkg::TRACK : tsfs_pkg::VERIFY;
                    end
                end
                tsfs_pkg::VERIFY:
                begin
                    if (atBoundary && isSync)
                    begin
                        hitCount_q <= hitCount_q + 8'h01;
                        if (hitCount_q + 8'h01 >= acqThresh_q) // RULE10
                        begin
                            state_q <= tsfs_pkg::TRACK;
                            missCount_q <= 8'h00;
                        end
                    end
                    else if (atBoundary)
                    begin
                        // A payload lookalike broke the spacing; start the hunt over.
                        state_q <= tsfs_pkg::HUNT; // RULE10
                        hitCount_q <= 8'h00;
                    end
                end
                tsfs_pkg::TRACK:
                begin
                    if (atBoundary && isSync)
                    begin
                        missCount_q <= 8'h00;
                    end
                    else if (atBoundary)
                    begin
                        missCount_q <= missCount_q + 8'h01;
                        if (missCount_q + 8'h01 >= trkThresh_q) // RULE10
                        begin
                            state_q <= tsfs_pkg::HUNT;
                            hitCount_q <= 8'h00;
                        end
                    end
                end
                default: state_q <= tsfs_pkg::HUNT;
            endcase
        end
    end

    assign frameLockOut = (state_q == tsfs_pkg::TRACK); // RULE8

    // ----------------------------------------------------------------
    // Packet outputs
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            packetError_q <= 1'b0;
            packetStart_q <= 1'b0;
        end
        else
        begin
            packetError_q <= rsUncorrectable; // RULE9
            packetStart_q <= byteValid && frameLockOut && atBoundary && isSync && !acqRaised;
        end
    end

    assign packetErrorOut = packetError_q; // RULE9
    assign packetStartOut = packetStart_q;

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    assign lockGain = byteValid && !acqRaised && (state_q != tsfs_pkg::TRACK) &&
                      (((state_q == tsfs_pkg::HUNT) && isSync && (acqThresh_q <= 8'h01)) ||
                       ((state_q == tsfs_pkg::VERIFY) && atBoundary && isSync &&
                        (hitCount_q + 8'h01 >= acqThresh_q)));
    assign lockLoss = (frameLockOut && acqRaised) ||
                      (byteValid && frameLockOut && atBoundary && !isSync &&
                       (missCount_q + 8'h01 >= trkThresh_q));
    always_comb
    begin
        irqEvents = '0;
        irqEvents[tsfs_pkg::IRQ_LOCK_GAIN_BIT] = lockGain;
        irqEvents[tsfs_pkg::IRQ_LOCK_LOSS_BIT] = lockLoss;
        irqEvents[tsfs_pkg::IRQ_UNCORR_BIT] = rsUncorrectable && !packetError_q;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irqStatus_q <= '0;
        end
        else if (wrEn && paddr == tsfs_pkg::IRQ_STATUS_ADDR)
        begin
            // New events win over a simultaneous write-one clear.
            irqStatus_q <= (irqStatus_q & ~pwdata[IRQ_W-1:0]) | irqEvents;
        end
        else
        begin
            irqStatus_q <= irqStatus_q | irqEvents;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irqMask_q <= '0;
        end
        else if (wrEn && paddr == tsfs_pkg::IRQ_MASK_ADDR)
        begin
            irqMask_q <= pwdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irqStatus_q & irqMask_q);
endmodule

// File: verif/tsfs_monitor.sv
// Checker of lock, packet error and register read behaviour at the top ports.
module tsfs_monitor
(
    input wire logic sys_clk, // Clock.
    input wire logic rst_b, // Reset, active low.
    input wire logic psel, // Select.
    input wire logic penable, // Access phase.
    input wire logic pwrite, // Direction.
    input wire logic [7:0] paddr, // Address.
    input wire logic [31:0] pwdata, // Write data.
    input wire logic [31:0] prdata, // Read data.
    input wire logic [7:0] byteIn, // Stream byte.
    input wire logic byteValid, // Byte strobe.
    input wire logic rsUncorrectable, // RS error.
    input wire logic tpsLock, // Signalling lock.
    input wire logic frameLockOut, // Lock.
    input wire logic packetErrorOut, // Packet error.
    input wire logic packetStartOut // Packet start.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic [7:0] acqThresh_q;
    wire apbWr = psel && penable && pwrite;
    wire apbRd = psel && penable && !pwrite;
    wire isSync = byteIn == tsfs_pkg::SYNC_NORMAL || byteIn == tsfs_pkg::SYNC_INVERTED;
    wire acqSel = paddr == tsfs_pkg::ACQ_THRESH_ADDR;

    // The shadow threshold lets a raise be told apart from a plain rewrite.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            acqThresh_q <= tsfs_pkg::ACQ_THRESH_RESET;
        else if (apbWr && acqSel)
            acqThresh_q <= pwdata[7:0];
    end

    a_err_delay: assert property (
        $past(rst_b) |-> packetErrorOut == $past(rsUncorrectable))
        else $error("Packet error does not follow the RS flag.");
    a_start_sync: assert property (
        packetStartOut |-> $past(byteValid) && $past(isSync))
        else $error("Packet start without a sync byte.");
    a_start_locked: assert property (
        packetStartOut |-> frameLockOut)
        else $error("Packet start while not locked.");
    a_lock_cause: assert property (
        $rose(frameLockOut) |-> $past(byteValid) && $past(isSync))
        else $error("Lock gained without a sync byte.");
    a_lock_drop: assert property (
        $fell(frameLockOut) |-> $past(byteValid) || $past(apbWr))
        else $error("Lock lost without a cause.");
    a_acq_raise: assert property (
        apbWr && acqSel && pwdata[7:0] > acqThresh_q |=> !frameLockOut)
        else $error("Raised threshold kept the lock.");
    a_acq_read: assert property (
        apbRd && acqSel |-> prdata == {24'h000000, acqThresh_q})
        else $error("Acquire threshold reads wrong.");
    a_tps_hidden: assert property (
        apbRd && paddr == tsfs_pkg::TPS_STATUS_ADDR && !tpsLock && !$past(tpsLock)
        |-> prdata == 32'h00000000)
        else $error("Code rate shown before signalling lock.");
    c_lock_gain: cover property ($rose(frameLockOut));
    c_lock_loss: cover property ($fell(frameLockOut));
    c_pkt_err: cover property (packetErrorOut && frameLockOut);
    c_pkt_start: cover property (packetStartOut);
endmodule

// File: verif/tsfs_ctrl_model.sv
// System controller model: APB master that reads status and programs the block.
module tsfs_ctrl_model
(
    input wire logic sys_clk, // Clock.
    input wire logic [31:0] prdata, // Read data.
    input wire logic pready, // Ready.
    input wire logic pslverr, // Error.
    output logic psel, // Select.
    output logic penable, // Access phase.
    output logic pwrite, // Direction.
    output logic [7:0] paddr, // Address.
    output logic [31:0] pwdata // Write data.
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data is inverted so that stale values cannot pass for valid ones.
        pwdata <= ~d;
    endtask

    task automatic copyRate;
        logic [31:0] q;
        logic [31:0] x;
        logic e;
        xfer(1'b0, tsfs_pkg::TPS_STATUS_ADDR, 32'h0, q, e);
        if (q[tsfs_pkg::TPS_VALID_BIT] === 1'b1)
            xfer(1'b1, tsfs_pkg::VIT_CONFIG_ADDR, {28'h0, 1'b1, q[2:0]}, x, e);
    endtask

    task automatic checkFalseLock(input logic [7:0] newAcq);
        logic [31:0] q;
        logic e;
        xfer(1'b0, tsfs_pkg::STATUS_ADDR, 32'h0, q, e);
        if (q[tsfs_pkg::STAT_LOCK_BIT] === 1'b1 && q[tsfs_pkg::STAT_UNCORR_BIT] === 1'b1)
            xfer(1'b1, tsfs_pkg::ACQ_THRESH_ADDR, {24'h0, newAcq}, q, e);
    endtask
endmodule

// File: verif/tb.sv
// Self-checking bench for the frame synchroniser.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, byteValid, err;
    logic rsUncorrectable, tpsLock, frameLockOut, packetErrorOut, packetStartOut;
    logic viterbiRateFixed, irq;
    logic [7:0] paddr, byteIn;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] tpsCodeRate, viterbiCodeRate;
    int error_cnt = 0;
    int check_count = 0;

    ts_frame_sync_control i_dut (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .byteIn, .byteValid, .rsUncorrectable, .tpsLock, .tpsCodeRate,
        .frameLockOut, .packetErrorOut, .packetStartOut, .viterbiCodeRate, .viterbiRateFixed, .irq);
    tsfs_ctrl_model i_ctrl (.sys_clk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite,
        .paddr, .pwdata);

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_ctrl.xfer(1'b1, a, d, rd, err);
        @(negedge sys_clk);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        i_ctrl.xfer(1'b0, a, 32'h0, rd, err);
        check(rd, exp);
    endtask

    // A packet is a sync position followed by filler that never matches a sync value.
    task automatic feed(input int n, input logic [7:0] s);
        repeat (n)
            for (int i = 0; i < 188; i++)
            begin
                @(posedge sys_clk);
                byteValid <= 1'b1;
                byteIn <= (i == 0) ? s : 8'h00;
            end
        @(posedge sys_clk);
        byteValid <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic testReset;
        rdChk(tsfs_pkg::ACQ_THRESH_ADDR, 32'h3);
        rdChk(tsfs_pkg::TRK_THRESH_ADDR, 32'h3);
        i_ctrl.xfer(1'b0, 8'h1C, 32'h0, rd, err);
        check({31'h0, err}, 32'h1);
        wr(tsfs_pkg::ACQ_THRESH_ADDR, 32'h3);
    endtask

    task automatic testLock;
        wr(tsfs_pkg::IRQ_MASK_ADDR, 32'h1);
        feed(2, 8'h47);
        check({31'h0, frameLockOut}, 32'h0);
        feed(1, 8'hB8);
        check({31'h0, frameLockOut}, 32'h1);
        check({31'h0, irq}, 32'h1);
        wr(tsfs_pkg::IRQ_STATUS_ADDR, 32'h1);
        check({31'h0, irq}, 32'h0);
        rdChk(tsfs_pkg::STATUS_ADDR, 32'h1);
    endtask

    task automatic testFalseLock;
        @(posedge sys_clk);
        rsUncorrectable <= 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        check({31'h0, packetErrorOut}, 32'h1);
        i_ctrl.checkFalseLock(8'h05);
        @(negedge sys_clk);
        check({31'h0, frameLockOut}, 32'h0);
        @(posedge sys_clk);
        rsUncorrectable <= 1'b0;
        feed(4, 8'h47);
        check({31'h0, frameLockOut}, 32'h0);
        feed(1, 8'h47);
        check({31'h0, frameLockOut}, 32'h1);
    endtask

    // One locked packet by hand, so that the start pulse can be seen in the cycle it stands.
    task automatic testStart;
        @(posedge sys_clk);
        byteValid <= 1'b1;
        byteIn <= 8'h47;
        @(posedge sys_clk);
        byteIn <= 8'h00;
        @(negedge sys_clk);
        check({31'h0, packetStartOut}, 32'h1);
        repeat (187) @(posedge sys_clk);
        byteValid <= 1'b0;
        @(negedge sys_clk);
        check({31'h0, packetStartOut}, 32'h0);
        check({31'h0, frameLockOut}, 32'h1);
    endtask

    task automatic testLoss;
        wr(tsfs_pkg::TRK_THRESH_ADDR, 32'h2);
        rdChk(tsfs_pkg::TRK_THRESH_ADDR, 32'h2);
        feed(1, 8'h00);
        check({31'h0, frameLockOut}, 32'h1);
        feed(1, 8'h00);
        check({31'h0, frameLockOut}, 32'h0);
    endtask

    task automatic testRate;
        rdChk(tsfs_pkg::TPS_STATUS_ADDR, 32'h0);
        @(posedge sys_clk);
        tpsLock <= 1'b1;
        tpsCodeRate <= 3'h5;
        rdChk(tsfs_pkg::TPS_STATUS_ADDR, 32'h85);
        i_ctrl.copyRate;
        @(negedge sys_clk);
        check({28'h0, viterbiRateFixed, viterbiCodeRate}, 32'hD);
    endtask

    // A second reset mid-run: the thresholds written earlier must not survive it.
    task automatic testRestore;
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        rdChk(tsfs_pkg::ACQ_THRESH_ADDR, 32'h3);
        rdChk(tsfs_pkg::TRK_THRESH_ADDR, 32'h3);
        check({28'h0, viterbiRateFixed, viterbiCodeRate}, 32'h0);
    endtask

    initial
    begin
        rst_b = 1'b0;
        byteValid = 1'b0;
        byteIn = 8'h00;
        rsUncorrectable = 1'b0;
        tpsLock = 1'b0;
        tpsCodeRate = 3'h0;
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        testReset;
        testLock;
        testFalseLock;
        testStart;
        testLoss;
        testRate;
        testRestore;
        stop_test;
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        stop_test;
    end
endmodule

bind ts_frame_sync_control tsfs_monitor i_mon (.sys_clk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .byteIn, .byteValid, .rsUncorrectable, .tpsLock, .frameLockOut,
    .packetErrorOut, .packetStartOut);
